// ==== logic/rsfl_pkg.sv ====
// Package with register map, field positions, reset values and codes for the reset cause logic
package rsfl_pkg;

    // Register byte addresses on the AXI4-Lite bus
    localparam logic [7:0] ADDR_CAUSE = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_PROG_CTRL = 8'h08;
    localparam logic [7:0] ADDR_RST_CTRL = 8'h0C;
    localparam logic [7:0] ADDR_LV_SEL = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
    localparam logic [7:0] ADDR_CPU = 8'h1C;

    // Reset cause flag positions
    localparam int BIT_WDG_REG = 0;
    localparam int BIT_LV_REG = 1;
    localparam int BIT_LV_RST = 2;
    localparam int BIT_RST_CTRL = 3;
    localparam logic [3:0] CAUSE_IMPL_MASK = 4'hF;

    // Status flag positions
    localparam int BIT_PDF = 0;
    localparam int BIT_TO = 1;

    // Interrupt event positions
    localparam int EV_RST_CTRL = 0;
    localparam int EV_LV_RST = 1;
    localparam int EV_LV_REG = 2;
    localparam int EV_WDG_REG = 3;
    localparam int EV_WDG_TO = 4;
    localparam int EV_PROG = 5;
    localparam int EV_NUM = 6;

    // Reset values, valid register codes and programming key
    localparam logic [3:0] CAUSE_POR = 4'h0;
    localparam logic [7:0] RST_CTRL_POR = 8'h55;
    localparam logic [7:0] RST_CTRL_PIN = 8'hAA;
    localparam logic [7:0] LV_SEL_POR = 8'h66;
    localparam logic [7:0] LV_SEL_1V9 = 8'h55;
    localparam logic [7:0] LV_SEL_2V55 = 8'h33;
    localparam logic [7:0] LV_SEL_3V15 = 8'h99;
    localparam logic [7:0] LV_SEL_3V8 = 8'hAA;
    localparam logic [7:0] LV_SEL_OFF = 8'hF0;
    localparam logic [7:0] PROG_KEY = 8'h55;
    localparam logic [15:0] PC_ZERO = 16'h0000;
    localparam logic [7:0] SP_ZERO = 8'h00;

    // Length of the reset pulse sent to the core, in cycles
    localparam logic [3:0] RST_PULSE_CYC = 4'h4;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Kinds of reset applied to the core
    typedef enum logic [2:0] {
        RSFL_RST_NONE = 3'b000,
        RSFL_RST_FULL = 3'b001,
        RSFL_RST_WARM = 3'b010,
        RSFL_RST_SLEEP_WDG = 3'b011
    } rsfl_rst_kind_type;

endpackage : rsfl_pkg

// ==== logic/rsfl_pulse.sv ====
// Stretches a reset request into a fixed-length reset pulse for the core
module rsfl_pulse #(
    parameter logic [3:0] LEN = rsfl_pkg::RST_PULSE_CYC
) (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic start_i,
    output logic busy_o
);
    typedef struct packed {
        logic [3:0] cnt;
    } rsfl_pulse_state_type;

    rsfl_pulse_state_type s_q;
    rsfl_pulse_state_type s_d;

    always_comb begin
        s_d = s_q;
        if (start_i) begin
            s_d.cnt = LEN;
        end else if (s_q.cnt != 4'h0) begin
            s_d.cnt = s_q.cnt - 4'h1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign busy_o = (s_q.cnt != 4'h0);
endmodule : rsfl_pulse

// ==== logic/rsfl_top.sv ====
// Reset cause flags, reset request logic and AXI4-Lite register slave
// Functional notes
// - Bits 7 to 4 of the reset cause register read as zero and ignore writes.
// - A valid low-supply event sets the low-voltage reset flag.
// - An undefined low-voltage select value causes a reset and sets the low-voltage-register flag.
// - Each reset flag stays set until software writes zero to it; no hardware event clears it.
// - A reset from the internal reset control register sets the reset-control flag.
// - Writing the key into the programming control register resets the whole device.
// - A watchdog timeout while running resets the device and sets the timeout flag.
// - A watchdog timeout in sleep or idle keeps most register contents.
// - A watchdog timeout in sleep or idle clears program counter and stack pointer.
// - A watchdog timeout in sleep or idle sets both timeout and power-down flags.
//
// The implementer's own choices: the register offsets and register access over AXI4-Lite.
module rsfl_top (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic low_voltage_reset_i,
    input wire logic wdg_timeout_i,
    input wire logic wdg_reg_fault_i,
    input wire logic sleep_i,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic core_rst_o,
    output logic [2:0] core_rst_kind_o,
    output logic pc_sp_clear_o,
    output logic irq_o
);
    localparam int EV_NUM_W = rsfl_pkg::EV_NUM;

    typedef struct packed {
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [3:0] cause;
        logic [1:0] status;
        logic [7:0] rst_ctrl;
        logic [7:0] lv_sel;
        logic [7:0] prog_ctrl;
        logic [EV_NUM_W-1:0] irq_stat;
        logic [EV_NUM_W-1:0] irq_mask;
        logic [2:0] rst_kind;
        logic pc_sp_clear;
        logic [15:0] pc;
        logic [7:0] sp;
    } rsfl_state_type;

    rsfl_state_type s_q;
    rsfl_state_type s_d;
    logic pulse_busy;
    logic rst_start;

    function automatic logic lv_sel_valid(input logic [7:0] v);
        lv_sel_valid = (v == rsfl_pkg::LV_SEL_POR) || (v == rsfl_pkg::LV_SEL_1V9) ||
            (v == rsfl_pkg::LV_SEL_2V55) || (v == rsfl_pkg::LV_SEL_3V15) ||
            (v == rsfl_pkg::LV_SEL_3V8) || (v == rsfl_pkg::LV_SEL_OFF);
    endfunction : lv_sel_valid

    function automatic logic rst_ctrl_valid(input logic [7:0] v);
        rst_ctrl_valid = (v == rsfl_pkg::RST_CTRL_POR) || (v == rsfl_pkg::RST_CTRL_PIN);
    endfunction : rst_ctrl_valid

    function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] d, input logic [3:0] st);
        merge_byte = st[0] ? d[7:0] : old;
    endfunction : merge_byte

    always_comb begin
        logic wr_fire;
        logic [EV_NUM_W-1:0] ev;
        logic [7:0] wb;
        wr_fire = 1'b0;
        ev = '0;
        wb = 8'h00;
        s_d = s_q;
        rst_start = 1'b0;

        // Write channel capture, in either order
        if (s_axi_awvalid && !s_q.aw_got) begin
            s_d.aw_got = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_q.w_got) begin
            s_d.w_got = 1'b1;
            s_d.w_data = s_axi_wdata;
            s_d.w_strb = s_axi_wstrb;
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end

        // Register write
        if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
            wr_fire = 1'b1;
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = rsfl_pkg::RESP_OKAY;
            wb = s_q.w_data[7:0];
            case (s_q.aw_addr)
                rsfl_pkg::ADDR_CAUSE: begin
                    if (s_q.w_strb[0]) begin
                        s_d.cause = s_q.cause & wb[3:0];
                    end
                end
                rsfl_pkg::ADDR_STATUS: begin
                    if (s_q.w_strb[0]) begin
                        s_d.status = wb[1:0];
                    end
                end
                rsfl_pkg::ADDR_PROG_CTRL: begin
                    s_d.prog_ctrl = merge_byte(s_q.prog_ctrl, s_q.w_data, s_q.w_strb);
                end
                rsfl_pkg::ADDR_RST_CTRL: begin
                    s_d.rst_ctrl = merge_byte(s_q.rst_ctrl, s_q.w_data, s_q.w_strb);
                end
                rsfl_pkg::ADDR_LV_SEL: begin
                    s_d.lv_sel = merge_byte(s_q.lv_sel, s_q.w_data, s_q.w_strb);
                end
                rsfl_pkg::ADDR_IRQ_STAT: begin
                    if (s_q.w_strb[0]) begin
                        s_d.irq_stat = s_q.irq_stat & ~wb[EV_NUM_W-1:0];
                    end
                end
                rsfl_pkg::ADDR_IRQ_MASK: begin
                    if (s_q.w_strb[0]) begin
                        s_d.irq_mask = wb[EV_NUM_W-1:0];
                    end
                end
                rsfl_pkg::ADDR_CPU: begin
                end
                default: begin
                    s_d.bresp = rsfl_pkg::RESP_SLVERR;
                end
            endcase
        end

        // Register read
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !s_q.rvalid) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = rsfl_pkg::RESP_OKAY;
            s_d.rdata = 32'h0000_0000;
            case (s_axi_araddr)
                rsfl_pkg::ADDR_CAUSE: s_d.rdata = {28'h0000000, s_q.cause};
                rsfl_pkg::ADDR_STATUS: s_d.rdata = {30'h00000000, s_q.status};
                rsfl_pkg::ADDR_PROG_CTRL: s_d.rdata = {24'h000000, s_q.prog_ctrl};
                rsfl_pkg::ADDR_RST_CTRL: s_d.rdata = {24'h000000, s_q.rst_ctrl};
                rsfl_pkg::ADDR_LV_SEL: s_d.rdata = {24'h000000, s_q.lv_sel};
                rsfl_pkg::ADDR_IRQ_STAT: s_d.rdata = {26'h0000000, s_q.irq_stat};
                rsfl_pkg::ADDR_IRQ_MASK: s_d.rdata = {26'h0000000, s_q.irq_mask};
                rsfl_pkg::ADDR_CPU: s_d.rdata = {8'h00, s_q.sp, s_q.pc};
                default: s_d.rresp = rsfl_pkg::RESP_SLVERR;
            endcase
        end

        // Reset sources: register settings checked on registered values, input events sampled directly; ignored while a reset pulse is running
        s_d.pc_sp_clear = 1'b0;
        if (!pulse_busy) begin
            s_d.rst_kind = rsfl_pkg::RSFL_RST_NONE;
            if (s_q.prog_ctrl == rsfl_pkg::PROG_KEY) begin
                ev[rsfl_pkg::EV_PROG] = 1'b1;
                s_d.rst_kind = rsfl_pkg::RSFL_RST_FULL;
            end else if (wdg_timeout_i && sleep_i) begin
                ev[rsfl_pkg::EV_WDG_TO] = 1'b1;
                s_d.rst_kind = rsfl_pkg::RSFL_RST_SLEEP_WDG;
                s_d.status[rsfl_pkg::BIT_TO] = 1'b1;
                s_d.status[rsfl_pkg::BIT_PDF] = 1'b1;
                s_d.pc = rsfl_pkg::PC_ZERO;
                s_d.sp = rsfl_pkg::SP_ZERO;
                s_d.pc_sp_clear = 1'b1;
            end else if (wdg_timeout_i) begin
                ev[rsfl_pkg::EV_WDG_TO] = 1'b1;
                s_d.rst_kind = rsfl_pkg::RSFL_RST_WARM;
                s_d.status[rsfl_pkg::BIT_TO] = 1'b1;
                s_d.pc = rsfl_pkg::PC_ZERO;
                s_d.sp = rsfl_pkg::SP_ZERO;
            end else if (!rst_ctrl_valid(s_q.rst_ctrl)) begin
                ev[rsfl_pkg::EV_RST_CTRL] = 1'b1;
                s_d.rst_kind = rsfl_pkg::RSFL_RST_WARM;
                s_d.cause[rsfl_pkg::BIT_RST_CTRL] = 1'b1;
            end else if (!lv_sel_valid(s_q.lv_sel)) begin
                ev[rsfl_pkg::EV_LV_REG] = 1'b1;
                s_d.rst_kind = rsfl_pkg::RSFL_RST_WARM;
                s_d.cause[rsfl_pkg::BIT_LV_REG] = 1'b1;
            end else if (low_voltage_reset_i && !sleep_i && s_q.lv_sel != rsfl_pkg::LV_SEL_OFF) begin
                ev[rsfl_pkg::EV_LV_RST] = 1'b1;
                s_d.rst_kind = rsfl_pkg::RSFL_RST_WARM;
                s_d.cause[rsfl_pkg::BIT_LV_RST] = 1'b1;
            end else if (wdg_reg_fault_i) begin
                ev[rsfl_pkg::EV_WDG_REG] = 1'b1;
                s_d.rst_kind = rsfl_pkg::RSFL_RST_WARM;
                s_d.cause[rsfl_pkg::BIT_WDG_REG] = 1'b1;
            end
            if (s_d.rst_kind != rsfl_pkg::RSFL_RST_NONE) begin
                rst_start = 1'b1;
                if (s_d.rst_kind != rsfl_pkg::RSFL_RST_SLEEP_WDG) begin
                    // Control registers return to power-on values; kept on sleep timeout
                    s_d.rst_ctrl = rsfl_pkg::RST_CTRL_POR;
                    s_d.lv_sel = rsfl_pkg::LV_SEL_POR;
                    s_d.prog_ctrl = 8'h00;
                    s_d.irq_mask = '0;
                end
                if (s_d.rst_kind == rsfl_pkg::RSFL_RST_FULL) begin
                    s_d.pc = rsfl_pkg::PC_ZERO;
                    s_d.sp = rsfl_pkg::SP_ZERO;
                end
            end
        end

        // Sticky interrupt status; the event wins over a same-cycle clear
        s_d.irq_stat = s_d.irq_stat | ev;
        if (wr_fire) begin
            s_d.w_strb = s_d.w_strb;
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_q <= '0;
            s_q.cause <= rsfl_pkg::CAUSE_POR;
            s_q.rst_ctrl <= rsfl_pkg::RST_CTRL_POR;
            s_q.lv_sel <= rsfl_pkg::LV_SEL_POR;
            s_q.rst_kind <= rsfl_pkg::RSFL_RST_NONE;
        end else begin
            s_q <= s_d;
        end
    end

    rsfl_pulse #(
        .LEN(rsfl_pkg::RST_PULSE_CYC)
    ) u_pulse (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .start_i(rst_start),
        .busy_o(pulse_busy)
    );

    assign s_axi_awready = !s_q.aw_got;
    assign s_axi_wready = !s_q.w_got;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = !s_q.rvalid;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
    assign core_rst_o = pulse_busy;
    assign core_rst_kind_o = s_q.rst_kind;
    assign pc_sp_clear_o = s_q.pc_sp_clear;
    assign irq_o = |(s_q.irq_stat & s_q.irq_mask);
endmodule : rsfl_top

// ==== tb/rsfl_monitor.sv ====
// Checker of reset requests, bus answers and read-back of the reset cause logic
module rsfl_monitor (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic low_voltage_reset_i,
    input wire logic wdg_timeout_i,
    input wire logic sleep_i,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic core_rst_o,
    input wire logic [2:0] core_rst_kind_o,
    input wire logic pc_sp_clear_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rd_addr_q;
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_addr_q <= 8'h00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rd_addr_q <= s_axi_araddr;
        end
    end
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!arst_n_i);
    sequence s_rst_pulse;
        core_rst_o [*4] ##1 !core_rst_o;
    endsequence
    sequence s_rst_start;
        ##[1:6] core_rst_o;
    endsequence
    chk_cause_upper: assert property (s_axi_rvalid && rd_addr_q == rsfl_pkg::ADDR_CAUSE |->
        s_axi_rdata[31:4] == 28'h0000000) else $error("cause upper bits not zero");
    chk_rst_len: assert property ($rose(core_rst_o) |-> s_rst_pulse)
        else $error("core reset pulse length wrong");
    chk_rst_kind: assert property ($rose(core_rst_o) |-> ##[0:4] core_rst_kind_o != rsfl_pkg::RSFL_RST_NONE)
        else $error("core reset without kind");
    chk_lv_reset: assert property (low_voltage_reset_i && !sleep_i && !core_rst_o |-> s_rst_start)
        else $error("low supply gave no reset");
    chk_wdg_reset: assert property (wdg_timeout_i && !sleep_i && !core_rst_o |-> s_rst_start)
        else $error("watchdog gave no reset");
    chk_sleep_clear: assert property (wdg_timeout_i && sleep_i && !core_rst_o |-> ##[1:6] pc_sp_clear_o)
        else $error("sleep watchdog gave no clear");
    chk_clear_once: assert property (pc_sp_clear_o |=> !pc_sp_clear_o)
        else $error("clear pulse too long");
    chk_sleep_kind: assert property ($rose(pc_sp_clear_o) |->
        ##[0:6] core_rst_kind_o == rsfl_pkg::RSFL_RST_SLEEP_WDG) else $error("sleep reset kind wrong");
    chk_unmapped_read: assert property (s_axi_rvalid && rd_addr_q > rsfl_pkg::ADDR_CPU |->
        s_axi_rresp == rsfl_pkg::RESP_SLVERR) else $error("unmapped read not refused");
endmodule : rsfl_monitor

bind rsfl_top rsfl_monitor u_mon (.sys_clk_i, .arst_n_i, .low_voltage_reset_i, .wdg_timeout_i, .sleep_i,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .core_rst_o, .core_rst_kind_o, .pc_sp_clear_o);

// ==== tb/rsfl_top_tb.sv ====
// Self-checking bench of the reset cause logic
module rsfl_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] r;} rsfl_row_type;
    logic sys_clk_i = 1'h0, arst_n_i = 1'h0, sleep_i = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, pcs = 1'h0;
    logic low_voltage_reset_i, wdg_timeout_i, wdg_reg_fault_i;
    logic [2:0] ev = 3'h0, kind;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h00000000, rd;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, core_rst_o, pc_sp_clear_o, irq_o;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs, bs;
    logic [31:0] s_axi_rdata;
    logic [2:0] core_rst_kind_o;
    int n_errors = 0, checks = 0, cyc = 0;
    rsfl_row_type rows [9] = '{'{rsfl_pkg::ADDR_CAUSE, 32'h0, 2'h0}, '{rsfl_pkg::ADDR_STATUS, 32'h0, 2'h0},
        '{rsfl_pkg::ADDR_PROG_CTRL, 32'h0, 2'h0}, '{rsfl_pkg::ADDR_RST_CTRL, 32'h55, 2'h0},
        '{rsfl_pkg::ADDR_LV_SEL, 32'h66, 2'h0}, '{rsfl_pkg::ADDR_IRQ_STAT, 32'h0, 2'h0},
        '{rsfl_pkg::ADDR_IRQ_MASK, 32'h0, 2'h0}, '{rsfl_pkg::ADDR_CPU, 32'h0, 2'h0},
        '{8'h20, 32'h0, rsfl_pkg::RESP_SLVERR}};
    assign low_voltage_reset_i = ev[0];
    assign wdg_timeout_i = ev[1];
    assign wdg_reg_fault_i = ev[2];
    rsfl_top dut (.sys_clk_i, .arst_n_i, .low_voltage_reset_i, .wdg_timeout_i, .wdg_reg_fault_i, .sleep_i,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .core_rst_o, .core_rst_kind_o, .pc_sp_clear_o, .irq_o);
    always #4 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        cyc++;
        if (pc_sp_clear_o === 1'h1) pcs <= 1'h1;
        if (cyc == 5000) begin
            n_errors++;
            test_done();
        end
    end
    task automatic test_done;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge sys_clk_i);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= 1'h0;
        bs = s_axi_bresp;
    endtask : wr
    task automatic expect_reg(input string nm, input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge sys_clk_i);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        s_axi_rready <= 1'h0;
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        check(nm, e, rd);
    endtask : expect_reg
    task automatic pulse(input logic [2:0] m);
        @(posedge sys_clk_i);
        ev <= m;
        @(posedge sys_clk_i);
        ev <= 3'h0;
    endtask : pulse
    task automatic wait_rst;
        while (core_rst_o !== 1'h1) @(posedge sys_clk_i);
        kind = core_rst_kind_o;
        while (core_rst_o !== 1'h0) @(posedge sys_clk_i);
    endtask : wait_rst
    task automatic run_rows;
        for (int i = 0; i < 9; i++) begin
            expect_reg("reset row", rows[i].a, rows[i].d);
            check("reset row resp", 32'(rows[i].r), 32'(rs));
        end
    endtask : run_rows
    initial begin
        repeat (3) @(posedge sys_clk_i);
        arst_n_i <= 1'h1;
        run_rows();
        pulse(3'h1);
        wait_rst();
        expect_reg("cause lv", rsfl_pkg::ADDR_CAUSE, 32'h4);
        wr(rsfl_pkg::ADDR_LV_SEL, 8'h12);
        wait_rst();
        expect_reg("cause lv_sel", rsfl_pkg::ADDR_CAUSE, 32'h6);
        expect_reg("lv_sel back", rsfl_pkg::ADDR_LV_SEL, 32'h66);
        wr(rsfl_pkg::ADDR_RST_CTRL, 8'h12);
        wait_rst();
        expect_reg("cause rst_ctrl", rsfl_pkg::ADDR_CAUSE, 32'hE);
        pulse(3'h4);
        wait_rst();
        wr(rsfl_pkg::ADDR_CAUSE, 8'hFB);
        check("write resp", 32'(rsfl_pkg::RESP_OKAY), 32'(bs));
        expect_reg("cause clear", rsfl_pkg::ADDR_CAUSE, 32'hB);
        wr(rsfl_pkg::ADDR_PROG_CTRL, rsfl_pkg::PROG_KEY);
        wait_rst();
        check("kind key", 32'(rsfl_pkg::RSFL_RST_FULL), 32'(kind));
        wr(rsfl_pkg::ADDR_STATUS, 8'h00);
        pulse(3'h2);
        wait_rst();
        check("kind wdg", 32'(rsfl_pkg::RSFL_RST_WARM), 32'(kind));
        expect_reg("status wdg", rsfl_pkg::ADDR_STATUS, 32'h2);
        wr(rsfl_pkg::ADDR_IRQ_MASK, 8'h3F);
        wr(rsfl_pkg::ADDR_STATUS, 8'h00);
        sleep_i <= 1'h1;
        pulse(3'h2);
        wait_rst();
        sleep_i <= 1'h0;
        check("kind sleep", 32'(rsfl_pkg::RSFL_RST_SLEEP_WDG), 32'(kind));
        check("pc sp clear", 32'h1, 32'(pcs));
        expect_reg("status sleep", rsfl_pkg::ADDR_STATUS, 32'h3);
        expect_reg("mask kept", rsfl_pkg::ADDR_IRQ_MASK, 32'h3F);
        check("irq on", 32'h1, 32'(irq_o));
        wr(rsfl_pkg::ADDR_IRQ_MASK, 8'h00);
        check("irq masked", 32'h0, 32'(irq_o));
        wr(rsfl_pkg::ADDR_IRQ_MASK, 8'h3F);
        check("irq unmasked", 32'h1, 32'(irq_o));
        wr(rsfl_pkg::ADDR_IRQ_STAT, 8'h3F);
        check("irq cleared", 32'h0, 32'(irq_o));
        sleep_i <= 1'h1;
        pulse(3'h1);
        sleep_i <= 1'h0;
        repeat (2) @(posedge sys_clk_i);
        check("lv in sleep", 32'h0, 32'(core_rst_o));
        expect_reg("cause sleep lv", rsfl_pkg::ADDR_CAUSE, 32'hB);
        wr(8'h20, 8'h00);
        check("unmapped write resp", 32'(rsfl_pkg::RESP_SLVERR), 32'(bs));
        arst_n_i <= 1'h0;
        repeat (3) @(posedge sys_clk_i);
        arst_n_i <= 1'h1;
        run_rows();
        test_done();
    end
endmodule : rsfl_top_tb
